// *** core/twm_pkg.sv ***
// package of constants and types for the timer waveform output block
// Contract
// R1: reset clears waveform output state to zero
// R2: nonzero output mode overrides port value
// R3: software sets pin direction before expecting output
// R4: override ignores the counting mode
// R5: output mode zero leaves state unchanged
// R6: new output mode acts next match; force acts
// R7: counting depends only on mode select
// R8: normal mode only increments, wraps at ff
// R9: normal mode overflow flag set when count zero
// R10: software may write count anytime in normal
// R11: clear-on-match clears count at compare value
// R12: compare writes immediate; missed match wraps first
// R13: clear-on-match mode one toggles output state
// R14: clear-on-match overflow set rolling max to zero
// R15: fast pwm counts to max then clears
// R16: fast pwm clears on match, sets at bottom
// R17: output mode two non-inverted, three inverted
// R18: fast pwm overflow set reaching max
// R19: bottom compare spikes; max compare constant level
// R20: clear-on-match raises match flag at top
// R21: match flag set one tick after equality
// R22: compare double buffered in pwm modes only
// R23: force updates output, no flag, no counter change
// R24: count write blocks matches on next tick
package twm_pkg;

	// ************************************************************
	// register map on the apb slave
	// ************************************************************
	localparam logic [11:0] TWM_CTRL_ADDR   = 12'h000; // mode bits and force strobe
	localparam logic [11:0] TWM_COUNT_ADDR  = 12'h004; // count value
	localparam logic [11:0] TWM_CMP_ADDR    = 12'h008; // compare value (buffer in pwm)
	localparam logic [11:0] TWM_FLAG_ADDR   = 12'h00c; // flags, write one to clear
	localparam logic [11:0] TWM_PORT_ADDR   = 12'h010; // port value and direction

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int TWM_CTRL_FORCE_BIT = 7;   // force strobe, reads zero
	localparam int TWM_CTRL_WGM0_BIT  = 6;   // mode select low bit
	localparam int TWM_CTRL_COM_LSB   = 4;   // output mode field low bit
	localparam int TWM_CTRL_WGM1_BIT  = 3;   // mode select high bit
	localparam int TWM_FLAG_OVF_BIT   = 0;   // overflow flag
	localparam int TWM_FLAG_MATCH_BIT = 1;   // compare match flag
	localparam int TWM_PORT_VAL_BIT   = 0;   // general port value
	localparam int TWM_PORT_DIR_BIT   = 1;   // pin direction, one is output

	// ************************************************************
	// reset values and counter extremes
	// ************************************************************
	localparam logic [7:0]  TWM_BOTTOM    = 8'h00; // counter bottom
	localparam logic [7:0]  TWM_MAX       = 8'hff; // counter maximum
	localparam logic [7:0]  TWM_RST_BYTE  = 8'h00; // reset of byte registers
	localparam logic [31:0] TWM_RD_ZERO   = 32'h0000_0000; // unmapped read data
	localparam int          TWM_TICK_DIV  = 8;     // pclk cycles per timer tick

	// ************************************************************
	// mode encodings
	// ************************************************************
	typedef enum logic [1:0] {
		TWM_WGM_NORMAL = 2'h0, // free-running up counter
		TWM_WGM_PHASE  = 2'h1, // dual slope, not covered here
		TWM_WGM_CTC    = 2'h2, // clear on match
		TWM_WGM_FAST   = 2'h3  // single slope pwm
	} twm_wgm_t;

	typedef enum logic [1:0] {
		TWM_COM_OFF    = 2'h0, // no action, port not overridden
		TWM_COM_TOGGLE = 2'h1, // toggle on match
		TWM_COM_CLEAR  = 2'h2, // clear / non-inverted pwm
		TWM_COM_SET    = 2'h3  // set / inverted pwm
	} twm_com_t;

	// control fields carried together
	typedef struct packed {
		twm_wgm_t wgm; // waveform_mode_select
		twm_com_t com; // compare_output_mode
	} twm_ctrl_t;

	// pin pair for the waveform pin
	typedef struct packed {
		logic out; // driven level
		logic oe;  // high while driving
	} twm_pin_t;

endpackage : twm_pkg

// *** core/twm_timer.sv ***
// timer counting modes, compare unit and waveform output with apb registers
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module twm_timer
	import twm_pkg::*;
(
	input  wire logic        pclk,    // 40 mhz bus clock
	input  wire logic        presetn, // async reset, active low
	input  wire logic        psel,    // apb select
	input  wire logic        penable, // apb access phase
	input  wire logic        pwrite,  // apb direction
	input  wire logic [11:0] paddr,   // apb byte address
	input  wire logic [31:0] pwdata,  // apb write data
	output logic      [31:0] prdata,  // apb read data
	output logic             pready,  // apb ready
	output logic             pslverr, // apb error on unmapped
	output logic             pin_out, // waveform pin level
	output logic             pin_oe   // waveform pin drive enable
);

	// ************************************************************
	// state
	// ************************************************************
	twm_ctrl_t   ctrl;          // mode fields
	logic [7:0]  count_value;   // counter
	logic [7:0]  compare_value; // value seen by the comparator
	logic [7:0]  compare_buf;   // software-written buffer
	logic        wave_output_state; // internal output register
	logic        overflow_flag;     // sticky overflow
	logic        compare_match_flag; // sticky match
	logic        port_value;    // general port output
	logic        wave_pin_direction_bit; // port direction
	logic        block_match;   // suppress matches on next tick
	logic        match_seen;    // registered match for the flag
	logic [2:0]  div_cnt;       // tick divider
	logic        timer_tick;    // one-cycle tick enable

	// ************************************************************
	// bus decode
	// ************************************************************
	logic acc;      // access phase strobe
	logic wr;       // write taken this edge
	logic mapped;   // address hits a register
	logic wr_ctrl;  // control write
	logic wr_count; // count write
	logic wr_cmp;   // compare write
	logic wr_flag;  // flag clear write
	logic wr_port;  // port write
	logic force_compare_strobe; // force action now
	logic is_pwm;   // pwm modes use the buffer
	logic raw_eq;   // comparator equality
	logic match;    // effective match after blocking
	logic at_top;   // counter at top of sequence

	assign acc      = psel & penable;
	assign mapped   = (paddr == TWM_CTRL_ADDR) | (paddr == TWM_COUNT_ADDR) | (paddr == TWM_CMP_ADDR)
		| (paddr == TWM_FLAG_ADDR) | (paddr == TWM_PORT_ADDR);
	assign wr       = acc & pwrite & mapped;
	assign wr_ctrl  = wr & (paddr == TWM_CTRL_ADDR);
	assign wr_count = wr & (paddr == TWM_COUNT_ADDR);
	assign wr_cmp   = wr & (paddr == TWM_CMP_ADDR);
	assign wr_flag  = wr & (paddr == TWM_FLAG_ADDR);
	assign wr_port  = wr & (paddr == TWM_PORT_ADDR);
	assign is_pwm   = ctrl.wgm[0];
	// force only meaningful in non-pwm modes; uses the field already held
	assign force_compare_strobe = wr_ctrl & pwdata[TWM_CTRL_FORCE_BIT] & ~is_pwm; // R6

	// comparator and match blocking
	assign raw_eq = (count_value == compare_value);
	assign match  = raw_eq & timer_tick & ~block_match; // R24
	// top of sequence: compare in ctc, max otherwise
	assign at_top = (ctrl.wgm == TWM_WGM_CTC) ? raw_eq : (count_value == TWM_MAX); // R11

	// ************************************************************
	// apb answer, zero wait states
	// ************************************************************
	// ready every access phase; unmapped addresses answer with an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= TWM_RD_ZERO;
		end else begin
			pready  <= psel & ~penable; // registered, so high in the access phase
			pslverr <= psel & ~penable & ~mapped;
			prdata  <= TWM_RD_ZERO;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					TWM_CTRL_ADDR: begin
						prdata[TWM_CTRL_WGM0_BIT] <= ctrl.wgm[0];
						prdata[TWM_CTRL_WGM1_BIT] <= ctrl.wgm[1];
						prdata[TWM_CTRL_COM_LSB +: 2] <= ctrl.com;
					end
					TWM_COUNT_ADDR: prdata[7:0] <= count_value;
					TWM_CMP_ADDR:   prdata[7:0] <= is_pwm ? compare_buf : compare_value;
					TWM_FLAG_ADDR: begin
						prdata[TWM_FLAG_OVF_BIT]   <= overflow_flag;
						prdata[TWM_FLAG_MATCH_BIT] <= compare_match_flag;
					end
					TWM_PORT_ADDR: begin
						prdata[TWM_PORT_VAL_BIT] <= port_value;
						prdata[TWM_PORT_DIR_BIT] <= wave_pin_direction_bit;
					end
					default: prdata <= TWM_RD_ZERO; // unmapped reads as zero
				endcase
			end
		end
	end

	// ************************************************************
	// tick divider
	// ************************************************************
	// fixed prescale stands in for the excluded clock select logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt    <= 3'h0;
			timer_tick <= 1'b0;
		end else begin
			div_cnt    <= div_cnt + 3'h1;
			timer_tick <= (div_cnt == 3'(TWM_TICK_DIV - 1));
		end
	end

	// ************************************************************
	// control and port registers
	// ************************************************************
	// output mode takes effect at the next match; no buffering of it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl                   <= '{wgm: TWM_WGM_NORMAL, com: TWM_COM_OFF};
			port_value             <= 1'b0;
			wave_pin_direction_bit <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl.wgm <= twm_wgm_t'({pwdata[TWM_CTRL_WGM1_BIT], pwdata[TWM_CTRL_WGM0_BIT]});
				ctrl.com <= twm_com_t'(pwdata[TWM_CTRL_COM_LSB +: 2]); // R6
			end
			if (wr_port) begin
				port_value             <= pwdata[TWM_PORT_VAL_BIT];
				wave_pin_direction_bit <= pwdata[TWM_PORT_DIR_BIT]; // R3
			end
		end
	end

	// ************************************************************
	// compare value and its buffer
	// ************************************************************
	// pwm modes load at bottom so a period never sees two values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_buf   <= TWM_RST_BYTE;
			compare_value <= TWM_RST_BYTE;
		end else begin
			if (wr_cmp) begin
				compare_buf <= pwdata[7:0];
			end
			if (!is_pwm) begin
				if (wr_cmp) begin
					compare_value <= pwdata[7:0]; // R22 R12
				end
			end else if (timer_tick && count_value == TWM_MAX) begin
				compare_value <= compare_buf; // R22
			end
		end
	end

	// compare path checks: direct in non-pwm modes, frozen between loads in pwm
	property p_cmp_direct;
		@(posedge pclk) disable iff (!presetn)
		(wr_cmp && !is_pwm) |=> compare_value == compare_buf;
	endproperty
	a_cmp_direct: assert property (p_cmp_direct) else $error("compare not written through"); // R22

	property p_cmp_hold;
		@(posedge pclk) disable iff (!presetn)
		(is_pwm && !(timer_tick && count_value == TWM_MAX)) |=> $stable(compare_value);
	endproperty
	a_cmp_hold: assert property (p_cmp_hold) else $error("compare changed outside its load point"); // R22

	// ************************************************************
	// counter
	// ************************************************************
	// software write wins over counting; sequence ignores output mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_value <= TWM_BOTTOM;
		end else if (wr_count) begin
			count_value <= pwdata[7:0]; // R10
		end else if (timer_tick) begin
			case (ctrl.wgm) // R7
				TWM_WGM_NORMAL: count_value <= count_value + 8'h01; // R8
				TWM_WGM_CTC: begin
					// missed top runs on through ff and wraps
					if (at_top && !block_match) count_value <= TWM_BOTTOM; // R11 R12
					else count_value <= count_value + 8'h01;
				end
				TWM_WGM_FAST: begin
					if (at_top) count_value <= TWM_BOTTOM; // R15
					else count_value <= count_value + 8'h01;
				end
				default: count_value <= count_value + 8'h01; // phase mode not covered
			endcase
		end
	end

	// counter checks: single slope wrap, force leaves the count alone
	property p_fast_wrap;
		@(posedge pclk) disable iff (!presetn)
		(timer_tick && !wr_count && ctrl.wgm == TWM_WGM_FAST && count_value == TWM_MAX)
		|=> count_value == TWM_BOTTOM;
	endproperty
	a_fast_wrap: assert property (p_fast_wrap) else $error("fast pwm did not restart at bottom"); // R15

	property p_force_count;
		@(posedge pclk) disable iff (!presetn)
		(force_compare_strobe && !timer_tick) |=> $stable(count_value) && $stable(compare_match_flag);
	endproperty
	a_force_count: assert property (p_force_count) else $error("force touched counter or flag"); // R23

	// ************************************************************
	// match blocking after count write
	// ************************************************************
	// held until the next timer tick has passed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			block_match <= 1'b0;
		end else if (wr_count) begin
			block_match <= 1'b1; // R24
		end else if (timer_tick) begin
			block_match <= 1'b0;
		end
	end

	// ************************************************************
	// flags
	// ************************************************************
	// set wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_flag      <= 1'b0;
			compare_match_flag <= 1'b0;
			match_seen         <= 1'b0;
		end else begin
			if (timer_tick) begin
				match_seen <= match; // flag follows on the next tick
			end
			if (timer_tick && match_seen) begin
				compare_match_flag <= 1'b1; // R21 R20
			end else if (wr_flag && pwdata[TWM_FLAG_MATCH_BIT]) begin
				compare_match_flag <= 1'b0;
			end
			// overflow when leaving max toward zero; never on a blocked write
			if (timer_tick && !wr_count && ctrl.wgm != TWM_WGM_PHASE && count_value == TWM_MAX) begin
				overflow_flag <= 1'b1; // R9 R14 R18
			end else if (wr_flag && pwdata[TWM_FLAG_OVF_BIT]) begin
				overflow_flag <= 1'b0;
			end
		end
	end

	// overflow when leaving max in clear-on-match and fast pwm
	property p_top_ovf;
		@(posedge pclk) disable iff (!presetn)
		(timer_tick && !wr_count && ctrl.wgm[1] && count_value == TWM_MAX) |=> overflow_flag;
	endproperty
	a_top_ovf: assert property (p_top_ovf) else $error("overflow not set leaving max"); // R14 R18

	// ************************************************************
	// waveform output state
	// ************************************************************
	// bottom action listed after match so compare at max holds a constant level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave_output_state <= 1'b0; // R1
		end else if (force_compare_strobe || (match && !is_pwm)) begin
			case (ctrl.com)
				TWM_COM_OFF:    wave_output_state <= wave_output_state; // R5
				TWM_COM_TOGGLE: wave_output_state <= ~wave_output_state; // R13 R23
				TWM_COM_CLEAR:  wave_output_state <= 1'b0;
				TWM_COM_SET:    wave_output_state <= 1'b1;
				default:        wave_output_state <= wave_output_state;
			endcase
		end else if (ctrl.wgm == TWM_WGM_FAST && timer_tick) begin
			// max compare: match and bottom coincide, match wins, level constant
			if (match && ctrl.com == TWM_COM_TOGGLE) begin
				wave_output_state <= ~wave_output_state;
			end else if (match && ctrl.com[1]) begin
				wave_output_state <= ctrl.com[0]; // R16 R17 R19
			end else if (count_value == TWM_MAX && ctrl.com[1]) begin
				wave_output_state <= ~ctrl.com[0]; // R16
			end
		end
	end

	// fast pwm match action per polarity
	property p_fast_clear;
		@(posedge pclk) disable iff (!presetn)
		(match && ctrl.wgm == TWM_WGM_FAST && ctrl.com == TWM_COM_CLEAR) |=> !wave_output_state;
	endproperty
	a_fast_clear: assert property (p_fast_clear) else $error("non-inverted pwm not cleared on match"); // R16 R17

	property p_fast_set;
		@(posedge pclk) disable iff (!presetn)
		(match && ctrl.wgm == TWM_WGM_FAST && ctrl.com == TWM_COM_SET) |=> wave_output_state;
	endproperty
	a_fast_set: assert property (p_fast_set) else $error("inverted pwm not set on match"); // R16 R17

	// ************************************************************
	// pin mux
	// ************************************************************
	// override depends only on the output mode, never on counting mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= 1'b0;
			pin_oe  <= 1'b0;
		end else begin
			pin_out <= (ctrl.com != TWM_COM_OFF) ? wave_output_state : port_value; // R2 R4
			pin_oe  <= wave_pin_direction_bit; // R2
		end
	end

	// port value passes with mode off; direction always from the port bit
	property p_port_pass;
		@(posedge pclk) disable iff (!presetn)
		ctrl.com == TWM_COM_OFF |=> pin_out == $past(port_value);
	endproperty
	a_port_pass: assert property (p_port_pass) else $error("port value not on pin"); // R2

	property p_oe_dir;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> pin_oe == $past(wave_pin_direction_bit);
	endproperty
	a_oe_dir: assert property (p_oe_dir) else $error("pin enable not following direction"); // R2

	// ************************************************************
	// checks
	// ************************************************************
	property p_reset_state;
		@(posedge pclk) $rose(presetn) |-> !wave_output_state;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("output state not zero after reset"); // R1

	property p_override;
		@(posedge pclk) disable iff (!presetn)
		ctrl.com != TWM_COM_OFF |=> pin_out == $past(wave_output_state);
	endproperty
	a_override: assert property (p_override) else $error("pin not following output state"); // R2

	property p_off_hold;
		@(posedge pclk) disable iff (!presetn)
		(match && ctrl.com == TWM_COM_OFF && !is_pwm) |=> $stable(wave_output_state);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("output changed with mode off"); // R5

	property p_ctc_toggle;
		@(posedge pclk) disable iff (!presetn)
		(match && ctrl.wgm == TWM_WGM_CTC && ctrl.com == TWM_COM_TOGGLE && !wr_ctrl)
		|=> wave_output_state != $past(wave_output_state);
	endproperty
	a_ctc_toggle: assert property (p_ctc_toggle) else $error("no toggle on match"); // R13

	property p_normal_wrap;
		@(posedge pclk) disable iff (!presetn)
		(timer_tick && !wr_count && ctrl.wgm == TWM_WGM_NORMAL && count_value == TWM_MAX)
		|=> count_value == TWM_BOTTOM && overflow_flag;
	endproperty
	a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap or overflow wrong"); // R9

	property p_ctc_clear;
		@(posedge pclk) disable iff (!presetn)
		(match && ctrl.wgm == TWM_WGM_CTC && !wr_count && !wr_ctrl) |=> count_value == TWM_BOTTOM;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) else $error("ctc did not clear"); // R11

	property p_flag_delay;
		@(posedge pclk) disable iff (!presetn)
		match ##1 (!timer_tick)[*7] ##1 timer_tick |=> compare_match_flag;
	endproperty
	a_flag_delay: assert property (p_flag_delay) else $error("match flag not set next tick"); // R21

	property p_block;
		@(posedge pclk) disable iff (!presetn)
		wr_count |=> !match;
	endproperty
	a_block: assert property (p_block) else $error("match not blocked after count write"); // R24

	property p_fast_bottom;
		@(posedge pclk) disable iff (!presetn)
		(timer_tick && ctrl.wgm == TWM_WGM_FAST && ctrl.com == TWM_COM_CLEAR && count_value == TWM_MAX
			&& !match && !wr_ctrl && !wr_count) |=> wave_output_state;
	endproperty
	a_fast_bottom: assert property (p_fast_bottom) else $error("fast pwm not set at bottom"); // R16

endmodule : twm_timer

// *** sim/twm_load.sv ***
// external load model hanging on the waveform pin
`timescale 1ns/1ps
module twm_load (
	input  wire logic pin_out,  // level offered by the block
	input  wire logic pin_oe,   // block drives the pin
	output logic      pin_level // level the load sees
);
	// ************************************************************
	// pin resolution
	// ************************************************************
	// released pin falls to the board pull-down, never keeps the last level
	assign pin_level = pin_oe ? pin_out : 1'b0;
endmodule : twm_load

// *** sim/twm_timer_tb.sv ***
// self-checking bench for the timer waveform block
`timescale 1ns/1ps
module twm_timer_tb import twm_pkg::*;;
	logic        pclk = 1'b0;    // 40 mhz bus clock
	logic        presetn = 1'b0; // reset, active low
	logic        psel = 1'b0;    // apb controls
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, pin_out, pin_oe, pin_level;
	logic [31:0] rd;  // read data of the last transfer
	logic        err; // error of the last transfer
	int          n_errors = 0;
	int          n_compared = 0;
	int          cyc = 0; // free cycle count for pin timing
	int          t0, t1, t2;

	always #12.5 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;

	twm_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_out(pin_out), .pin_oe(pin_oe));
	twm_load u_load (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) n_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask : wr

	task automatic rdv(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rdv

	// control byte: force, mode low, output mode, mode high
	function automatic logic [7:0] ctl(input twm_wgm_t w, input twm_com_t c, input logic f);
		return {f, w[0], c, w[1], 3'b000};
	endfunction : ctl

	// bounded wait for a pin level, returns the cycle stamp
	task automatic wait_pin(input logic v, output int t);
		int n;
		n = 0;
		while (pin_level !== v && n < 5000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 5000) n_errors++;
		t = cyc;
	endtask : wait_pin

	// poll the flag register until bit b is set
	task automatic poll_flag(input int b);
		int n;
		n = 0;
		do begin
			rdv(TWM_FLAG_ADDR);
			n++;
		end while (rd[b] !== 1'b1 && n < 1000);
		if (n >= 1000) n_errors++;
	endtask : poll_flag

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset();
		check({30'h0, pin_out, pin_oe}, 32'h0);
		rdv(TWM_CTRL_ADDR);
		check(rd, 32'h0);
		rdv(12'h0f0);
		check({rd[30:0], err}, 32'h1);
		wr(TWM_CMP_ADDR, 8'h80);
		wr(TWM_COUNT_ADDR, 8'h00); // keeps matches far away
		wr(TWM_PORT_ADDR, 8'h03);
		repeat (2) @(posedge pclk);
		check(pin_level, 1'b1);
		wr(TWM_CTRL_ADDR, ctl(TWM_WGM_NORMAL, TWM_COM_CLEAR, 1'b0));
		repeat (2) @(posedge pclk);
		check(pin_level, 1'b0);
		wr(TWM_PORT_ADDR, 8'h01);
		repeat (2) @(posedge pclk);
		check(pin_oe, 1'b0);
		wr(TWM_PORT_ADDR, 8'h03);
	endtask : t_reset

	// forced compares in normal mode, each acting with the output mode held from the write before
	task automatic t_force();
		wr(TWM_FLAG_ADDR, 8'h03);
		wr(TWM_CTRL_ADDR, ctl(TWM_WGM_NORMAL, TWM_COM_TOGGLE, 1'b0));
		wr(TWM_CTRL_ADDR, ctl(TWM_WGM_NORMAL, TWM_COM_TOGGLE, 1'b1));
		repeat (2) @(posedge pclk);
		check(pin_level, 1'b1);
		wr(TWM_CTRL_ADDR, ctl(TWM_WGM_NORMAL, TWM_COM_CLEAR, 1'b1));
		repeat (2) @(posedge pclk);
		check(pin_level, 1'b0);
		wr(TWM_CTRL_ADDR, ctl(TWM_WGM_NORMAL, TWM_COM_SET, 1'b1));
		wr(TWM_CTRL_ADDR, ctl(TWM_WGM_NORMAL, TWM_COM_OFF, 1'b1));
		wr(TWM_CTRL_ADDR, ctl(TWM_WGM_NORMAL, TWM_COM_TOGGLE, 1'b0));
		repeat (2) @(posedge pclk);
		check(pin_level, 1'b1);
		rdv(TWM_CTRL_ADDR);
		check(rd, {24'h0, ctl(TWM_WGM_NORMAL, TWM_COM_TOGGLE, 1'b0)});
		rdv(TWM_FLAG_ADDR);
		check(rd[1], 1'b0);
	endtask : t_force

	task automatic t_normal();
		wr(TWM_CTRL_ADDR, ctl(TWM_WGM_NORMAL, TWM_COM_OFF, 1'b0));
		wr(TWM_CMP_ADDR, 8'hf8);
		wr(TWM_COUNT_ADDR, 8'hf0);
		wr(TWM_FLAG_ADDR, 8'h03);
		repeat (32) @(posedge pclk);
		rdv(TWM_FLAG_ADDR);
		check(rd[0], 1'b0);
		poll_flag(0);
		rdv(TWM_COUNT_ADDR);
		check({31'h0, rd[7:0] < 8'h03}, 32'h1);
		repeat (40) @(posedge pclk);
		rdv(TWM_FLAG_ADDR);
		check(rd[1:0], 2'b11);
	endtask : t_normal

	task automatic t_ctc();
		wr(TWM_CMP_ADDR, 8'h05);
		wr(TWM_COUNT_ADDR, 8'h00);
		wr(TWM_CTRL_ADDR, ctl(TWM_WGM_CTC, TWM_COM_TOGGLE, 1'b0));
		wr(TWM_FLAG_ADDR, 8'h03);
		wait_pin(~pin_level, t0);
		wait_pin(~pin_level, t1);
		check(t1 - t0, 32'd48);
		rdv(TWM_FLAG_ADDR);
		check(rd[1:0], 2'b10);
		// count above the top must run through max before matching
		wr(TWM_COUNT_ADDR, 8'h10);
		wr(TWM_FLAG_ADDR, 8'h03);
		repeat (80) @(posedge pclk);
		rdv(TWM_FLAG_ADDR);
		check(rd[1], 1'b0);
		poll_flag(0);
		// count written equal to compare: that match is blocked
		wr(TWM_CMP_ADDR, 8'h40);
		wr(TWM_FLAG_ADDR, 8'h03);
		wr(TWM_COUNT_ADDR, 8'h40);
		repeat (40) @(posedge pclk);
		rdv(TWM_FLAG_ADDR);
		check(rd[1], 1'b0);
		rdv(TWM_COUNT_ADDR);
		check({31'h0, rd[7:0] > 8'h40}, 32'h1);
	endtask : t_ctc

	// fast pwm: hi is the expected high time in cycles, period 256 ticks
	task automatic t_pwm(input twm_com_t c, input logic [7:0] v, input int hi);
		wr(TWM_CMP_ADDR, v);
		wr(TWM_CTRL_ADDR, ctl(TWM_WGM_FAST, c, 1'b0));
		rdv(TWM_CMP_ADDR);
		check(rd, {24'h0, v});
		repeat (2100) @(posedge pclk);
		wait_pin(1'b0, t0);
		wait_pin(1'b1, t0);
		wait_pin(1'b0, t1);
		wait_pin(1'b1, t2);
		check(t1 - t0, hi);
		check(t2 - t0, 32'd2048);
	endtask : t_pwm

	// compare at max gives a steady level set by polarity
	task automatic t_steady(input twm_com_t c, input logic lvl);
		logic bad;
		bad = 1'b0;
		wr(TWM_CMP_ADDR, 8'hff);
		wr(TWM_CTRL_ADDR, ctl(TWM_WGM_FAST, c, 1'b0));
		// two bottoms: the first loads the buffer, the second matches at max
		repeat (4200) @(posedge pclk);
		wr(TWM_FLAG_ADDR, 8'h03);
		repeat (2100) begin
			@(posedge pclk);
			if (pin_level !== lvl) bad = 1'b1;
		end
		check(bad, 1'b0);
		poll_flag(0);
	endtask : t_steady

	// ************************************************************
	// closing and main sequence
	// ************************************************************
	task automatic print_verdict();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_force();
		t_normal();
		t_ctc();
		t_pwm(TWM_COM_CLEAR, 8'h40, 520);
		t_pwm(TWM_COM_SET, 8'h40, 1528);
		t_pwm(TWM_COM_CLEAR, 8'h00, 8);
		t_steady(TWM_COM_CLEAR, 1'b0);
		t_steady(TWM_COM_SET, 1'b1);
		print_verdict();
	end

	// watchdog, well beyond the roughly 30k cycles the run needs
	initial begin
		#(90000 * 25);
		n_errors++;
		print_verdict();
	end
endmodule : twm_timer_tb
